// [hpirq_pkg.sv]
// shared constants for the host port pin mux and report interrupt
package hpirq_pkg;
    localparam int unsigned REPORT_COUNT_W = 8;
    localparam logic [1:0]  MODE_I2C       = 2'h0;
    localparam logic [1:0]  MODE_SPI       = 2'h1;
    localparam logic [1:0]  MODE_LIN       = 2'h2;
    localparam logic [2:0]  GPIO_OE_RESET  = 3'h0;
    localparam logic [2:0]  GPIO_OUT_RESET = 3'h7;
    typedef enum logic [1:0] {
        HPIRQ_I2C,
        HPIRQ_SPI,
        HPIRQ_LIN
    } hpirq_mode_t;
endpackage : hpirq_pkg

// [hpirq_top.sv]
// host port pin mux, report pending interrupt and general purpose pins
//
// Notes on behaviour
// - interrupt pin driven low while any report waits to be read.
// - with nothing pending the pin is released, never driven high.
// - each host read consumes one report; release only when all consumed.
// - in lin mode the interrupt pin may become transceiver enable output.
// - pin a is i2c data, spi clock in, or lin receive in.
// - pin b is i2c clock in, spi select in, or lin transmit out.
// - three general purpose pins, weak pull-up, host configurable.
// - config may make io one hsync input and io two vsync input.
// - low hardware reset asynchronously returns everything to reset state.
// - names with _n are active low signals.
`timescale 1ns/100ps
`default_nettype none
module hpirq_top
    import hpirq_pkg::*;
#(
    parameter int unsigned COUNT_W = REPORT_COUNT_W
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        hw_reset_n,
    // mode and options
    input  wire logic [1:0]  mode_sel,
    input  wire logic        lin_enable_on_irq,
    input  wire logic        lin_transceiver_enable,
    input  wire logic        hsync_sel,
    input  wire logic        vsync_sel,
    // report queue events
    input  wire logic        report_queued,
    input  wire logic        report_consumed,
    output logic             reports_pending,
    // report interrupt pin, open drain
    output logic             report_pending_irq_n_o,
    output logic             report_pending_irq_n_oe_n,
    // host pin a
    input  wire logic        host_pin_a_i,
    output logic             host_pin_a_o,
    output logic             host_pin_a_oe_n,
    // host pin b
    input  wire logic        host_pin_b_i,
    output logic             host_pin_b_o,
    output logic             host_pin_b_oe_n,
    // protocol cores side
    input  wire logic        i2c_sda_drive_low,
    input  wire logic        lin_tx,
    output logic             i2c_sda_in,
    output logic             i2c_scl_in,
    output logic             spi_sck_in,
    output logic             slave_select_n,
    output logic             lin_rx,
    // general purpose pins
    input  wire logic [2:0]  gpio_pin_i,
    output logic [2:0]       gpio_pin_o,
    output logic [2:0]       gpio_pin_oe_n,
    input  wire logic [2:0]  gpio_out_set,
    input  wire logic [2:0]  gpio_dir_out,
    output logic [2:0]       gpio_in_val,
    output logic             hsync_in,
    output logic             vertical_or_external_sync_in
);
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic [1:0]         a_sync_reg;
    logic [1:0]         b_sync_reg;
    logic [2:0]         g_meta_reg;
    logic [2:0]         g_sync_reg;
    hpirq_mode_t        mode_reg;
    logic               lin_irq_en;
    logic               pending_next;

    // mode decode, shared by the host pin, core side and interrupt paths
    function automatic logic mode_is(
        input hpirq_mode_t cur,
        input hpirq_mode_t want
    );
        return (cur == want);
    endfunction : mode_is

    // one queued report is enough to hold the pin low
    function automatic logic any_pending(
        input logic [COUNT_W-1:0] cnt
    );
        return (cnt != '0);
    endfunction : any_pending

    // consume and queue in one cycle cancel; saturate to avoid wrap
    always_comb begin
        count_next = count_reg;
        if (report_queued && !report_consumed && count_reg != {COUNT_W{1'b1}}) begin
            count_next = count_reg + 1'b1;
        end else if (!report_queued && report_consumed && count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            mode_reg <= HPIRQ_I2C;
        end else begin
            case (mode_sel)
                MODE_I2C: mode_reg <= HPIRQ_I2C;
                MODE_SPI: mode_reg <= HPIRQ_SPI;
                MODE_LIN: mode_reg <= HPIRQ_LIN;
                default:  mode_reg <= HPIRQ_I2C;
            endcase
        end
    end

    assign lin_irq_en   = mode_is(mode_reg, HPIRQ_LIN) && lin_enable_on_irq;
    assign pending_next = any_pending(count_next);

    // pending flag moves on the same edge as the pin
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            reports_pending <= 1'b0;
        end else begin
            reports_pending <= pending_next;
        end
    end

    // pin always driven low or released; pull-up gives the high level
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            report_pending_irq_n_o    <= 1'b0;
            report_pending_irq_n_oe_n <= 1'b1;
        end else begin
            report_pending_irq_n_o <= 1'b0;
            if (lin_irq_en) begin
                report_pending_irq_n_oe_n <= lin_transceiver_enable;
            end else begin
                report_pending_irq_n_oe_n <= !pending_next;
            end
        end
    end

    // pin inputs: two flops before use
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            a_sync_reg <= 2'h3;
            b_sync_reg <= 2'h3;
            g_meta_reg <= 3'h7;
            g_sync_reg <= 3'h7;
        end else begin
            a_sync_reg <= {a_sync_reg[0], host_pin_a_i};
            b_sync_reg <= {b_sync_reg[0], host_pin_b_i};
            g_meta_reg <= gpio_pin_i;
            g_sync_reg <= g_meta_reg;
        end
    end

    // pin a: only i2c data ever drives it, and only low
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            host_pin_a_o    <= 1'b0;
            host_pin_a_oe_n <= 1'b1;
        end else begin
            host_pin_a_o    <= 1'b0;
            host_pin_a_oe_n <= !(mode_is(mode_reg, HPIRQ_I2C) && i2c_sda_drive_low);
        end
    end

    // pin b: driven only as lin transmit
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            host_pin_b_o    <= 1'b1;
            host_pin_b_oe_n <= 1'b1;
        end else begin
            host_pin_b_o    <= lin_tx;
            host_pin_b_oe_n <= !mode_is(mode_reg, HPIRQ_LIN);
        end
    end

    // core side: idle levels outside the active mode keep unused cores quiet
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            i2c_sda_in      <= 1'b1;
            i2c_scl_in      <= 1'b1;
            spi_sck_in      <= 1'b0;
            slave_select_n  <= 1'b1;
            lin_rx          <= 1'b1;
        end else begin
            i2c_sda_in      <= mode_is(mode_reg, HPIRQ_I2C) ? a_sync_reg[1] : 1'b1;
            spi_sck_in      <= mode_is(mode_reg, HPIRQ_SPI) ? a_sync_reg[1] : 1'b0;
            lin_rx          <= mode_is(mode_reg, HPIRQ_LIN) ? a_sync_reg[1] : 1'b1;
            i2c_scl_in      <= mode_is(mode_reg, HPIRQ_I2C) ? b_sync_reg[1] : 1'b1;
            slave_select_n  <= mode_is(mode_reg, HPIRQ_SPI) ? b_sync_reg[1] : 1'b1;
        end
    end

    // sync selection forces its pin to input
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            gpio_pin_o       <= GPIO_OUT_RESET;
            gpio_pin_oe_n    <= ~GPIO_OE_RESET;
        end else begin
            gpio_pin_o       <= gpio_out_set;
            gpio_pin_oe_n[0] <= !gpio_dir_out[0];
            gpio_pin_oe_n[1] <= !(gpio_dir_out[1] && !hsync_sel);
            gpio_pin_oe_n[2] <= !(gpio_dir_out[2] && !vsync_sel);
        end
    end

    // sync inputs read low while not selected
    always_ff @(posedge ref_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            gpio_in_val                  <= 3'h7;
            hsync_in                     <= 1'b0;
            vertical_or_external_sync_in <= 1'b0;
        end else begin
            gpio_in_val                  <= g_sync_reg;
            hsync_in                     <= hsync_sel && g_sync_reg[1];
            vertical_or_external_sync_in <= vsync_sel && g_sync_reg[2];
        end
    end
endmodule : hpirq_top
`default_nettype wire

// [hpirq_asserts.sv]
// concurrent checks on the host port pin mux and report interrupt
`timescale 1ns/100ps
`default_nettype none
module hpirq_asserts
    import hpirq_pkg::*;
(
    input wire logic       ref_clk, hw_reset_n, lin_enable_on_irq, lin_transceiver_enable, hsync_sel,
    input wire logic       report_queued, report_consumed, reports_pending, report_pending_irq_n_o,
    input wire logic       report_pending_irq_n_oe_n, host_pin_a_i, host_pin_a_oe_n, host_pin_b_i, host_pin_b_o,
    input wire logic       host_pin_b_oe_n, i2c_sda_drive_low, lin_tx, i2c_scl_in, spi_sck_in, slave_select_n,
    input wire logic       lin_rx, hsync_in,
    input wire logic [1:0] mode_sel,
    input wire logic [2:0] gpio_pin_i, gpio_pin_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!hw_reset_n);
    chk_irq_queued: assert property (report_queued && !report_consumed |=> reports_pending)
        else $error("no report pending after queue");
    chk_never_high: assert property (!report_pending_irq_n_o) else $error("irq pin driven high");
    chk_irq_tie: assert property ((mode_sel == MODE_I2C)[*3] |-> report_pending_irq_n_oe_n == !reports_pending)
        else $error("irq pin disagrees with pending");
    chk_hold_pending: assert property (reports_pending && !report_consumed |=> reports_pending)
        else $error("pending lost without a read");
    chk_lin_enable: assert property ((mode_sel == MODE_LIN && lin_enable_on_irq)[*3]
        |-> report_pending_irq_n_oe_n == $past(lin_transceiver_enable)) else $error("lin enable wrong");
    chk_spi_pins: assert property ((mode_sel == MODE_SPI)[*5] |-> spi_sck_in == $past(host_pin_a_i, 3)
        && slave_select_n == $past(host_pin_b_i, 3) && host_pin_a_oe_n && host_pin_b_oe_n) else $error("spi pins wrong");
    chk_lin_pins: assert property ((mode_sel == MODE_LIN)[*5] |-> lin_rx == $past(host_pin_a_i, 3)
        && host_pin_b_o == $past(lin_tx) && !host_pin_b_oe_n) else $error("lin pins wrong");
    chk_i2c_pins: assert property ((mode_sel == MODE_I2C)[*5] |-> i2c_scl_in == $past(host_pin_b_i, 3)
        && host_pin_a_oe_n == !$past(i2c_sda_drive_low)) else $error("i2c pins wrong");
    chk_gpio_sync: assert property (hsync_sel[*4] |-> gpio_pin_oe_n[1] && hsync_in == $past(gpio_pin_i[1], 3))
        else $error("hsync input wrong");
    chk_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0) !hw_reset_n
        |-> report_pending_irq_n_oe_n && !reports_pending && host_pin_a_oe_n) else $error("reset state wrong");
endmodule : hpirq_asserts
`default_nettype wire

// [hpirq_host_model.sv]
// host model: senses the interrupt by level and reads one report per service
`timescale 1ns/100ps
`default_nettype none
module hpirq_host_model (
    input  wire logic ref_clk,
    input  wire logic irq_line,
    input  wire logic host_en,
    input  wire logic slow,
    output logic      report_consumed
);
    int gap = 0;
    // gap of one or more: the pin settles on the same edge that takes the read
    always @(posedge ref_clk) begin
        if (host_en && irq_line === 1'b0 && gap == 0) begin
            report_consumed <= #2 1'b1;
            gap <= slow ? 5 : 2;
        end else begin
            report_consumed <= #2 1'b0;
            gap <= (gap > 0) ? gap - 1 : 0;
        end
    end
endmodule : hpirq_host_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the host port pin mux and report interrupt
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       ref_clk = 0, hw_reset_n = 1, lin_enable_on_irq = 0, lin_transceiver_enable = 0, hsync_sel = 0;
    logic       vsync_sel = 0, report_queued = 0, host_pin_a_i = 1, host_pin_b_i = 1, i2c_sda_drive_low = 0;
    logic       lin_tx = 1, host_en = 0, host_slow = 0;
    logic [1:0] mode_sel = 2'h0;
    logic [2:0] gpio_pin_i = 3'h7, gpio_out_set = 3'h7, gpio_dir_out = 3'h0;
    wire logic  report_consumed, reports_pending, report_pending_irq_n_o, report_pending_irq_n_oe_n, host_pin_a_o;
    wire logic  host_pin_a_oe_n, host_pin_b_o, host_pin_b_oe_n, i2c_sda_in, i2c_scl_in, spi_sck_in, slave_select_n;
    wire logic  lin_rx, hsync_in, vertical_or_external_sync_in;
    wire logic [2:0] gpio_pin_o, gpio_pin_oe_n, gpio_in_val;
    wire logic  irq_line = report_pending_irq_n_oe_n ? 1'b1 : report_pending_irq_n_o;
    int         err_total = 0, check_count = 0, n_read = 0;
    // mode, pin a, pin b, then sda, scl, sck, select, rx
    logic [8:0] rows [6] = '{9'h02B, 9'h053, 9'h0DD, 9'h0BB, 9'h11A, 9'h183};
    hpirq_top u_dut (.*);
    hpirq_host_model u_host (.ref_clk, .irq_line, .host_en, .slow(host_slow), .report_consumed);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (report_consumed === 1'b1) n_read++;
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : cyc
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #50000;
        err_total++;
        give_verdict();
    end
    initial begin
        #1;
        hw_reset_n = 0;
        cyc(4);
        hw_reset_n = 1;
        for (int i = 0; i < 6; i++) begin
            {mode_sel, host_pin_a_i, host_pin_b_i} = rows[i][8:5];
            cyc(6);
            check("pin function", 8'({i2c_sda_in, i2c_scl_in, spi_sck_in, slave_select_n, lin_rx}), 8'(rows[i][4:0]));
        end
        $display("pin function test done");
        {mode_sel, lin_enable_on_irq} = {2'h2, 1'b1};
        cyc(4);
        check("lin enable low", 8'(irq_line), 8'h00);
        lin_transceiver_enable = 1;
        cyc(2);
        check("lin enable high", 8'(irq_line), 8'h01);
        $display("lin enable test done");
        {mode_sel, lin_enable_on_irq} = {2'h0, 1'b0};
        {gpio_dir_out, gpio_out_set, gpio_pin_i} = {3'h5, 3'h4, 3'h2};
        cyc(4);
        check("gpio drive", 8'({gpio_pin_o, gpio_pin_oe_n}), 8'h22);
        check("gpio input", 8'(gpio_in_val), 8'h02);
        {hsync_sel, vsync_sel, gpio_dir_out} = {2'b11, 3'h7};
        cyc(4);
        check("sync inputs", 8'({gpio_pin_oe_n[2:1], hsync_in, vertical_or_external_sync_in}), 8'h0E);
        $display("gpio and sync test done");
        report_queued = 1;
        cyc(3);
        report_queued = 0;
        cyc(2);
        check("irq with reports", 8'({irq_line, reports_pending}), 8'h01);
        {host_en, host_slow} = 2'b11;
        for (int k = 0; k < 60 && irq_line !== 1'b1; k++) cyc(1);
        cyc(3);
        check("reads to release", 8'(n_read), 8'h03);
        check("irq released", 8'({irq_line, reports_pending}), 8'h02);
        host_en = 0;
        report_queued = 1;
        cyc(1);
        check("irq after requeue", 8'({irq_line, reports_pending}), 8'h01);
        report_queued = 0;
        cyc(2);
        hw_reset_n = 0;
        #1;
        check("async reset", 8'({irq_line, reports_pending}), 8'h02);
        cyc(2);
        hw_reset_n = 1;
        cyc(2);
        check("after reset", 8'({irq_line, reports_pending}), 8'h02);
        $display("report and reset test done");
        give_verdict();
    end
endmodule : testbench
bind hpirq_top hpirq_asserts u_chk (.*);
`default_nettype wire
